// ### core/pwmcg_clkgen.v
`timescale 1ns/1ps
`include "pwmcg_consts.vh"

module pwmcg_clkgen #(
  parameter TAPS  = `PWMCG_TAPS,
  parameter PRE_W = `PWMCG_PRE_W
) (
  // Clock and reset
  input  wire                        ref_clk_i,
  input  wire                        sys_rst_i,
  // Power management gate
  input  wire                        periph_clock_on_i,
  // Divider configuration
  input  wire [`PWMCG_SEL_W-1:0]     divider_a_tap_select_i,
  input  wire [`PWMCG_SEL_W-1:0]     divider_b_tap_select_i,
  input  wire [`PWMCG_FACTOR_W-1:0]  divider_a_factor_i,
  input  wire [`PWMCG_FACTOR_W-1:0]  divider_b_factor_i,
  // Clock ticks, one cycle each
  output wire [TAPS-1:0]             tap_tick_o,
  output wire                        divided_clock_a_o,
  output wire                        divided_clock_b_o
);

  // --------------------------------------------------------------------------
  // Modulo-n prescaler
  // --------------------------------------------------------------------------
  reg  [PRE_W-1:0] pre_q;

  // Holding the count while gated lets the taps resume where they left off
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_q <= `PWMCG_RST_PRE;
    end else if (periph_clock_on_i) begin
      pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  assign tap_tick_o[0] = 1'b1;

  genvar k;
  generate
    for (k = 1; k < TAPS; k = k + 1) begin : g_tap
      assign tap_tick_o[k] = periph_clock_on_i & (&pre_q[k-1:0]);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Linear dividers
  // --------------------------------------------------------------------------
  wire [2*`PWMCG_SEL_W-1:0]    div_sel    = {divider_b_tap_select_i, divider_a_tap_select_i};
  wire [2*`PWMCG_FACTOR_W-1:0] div_factor = {divider_b_factor_i, divider_a_factor_i};
  wire [1:0]                   div_out;

  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1) begin : g_div
      wire [`PWMCG_SEL_W-1:0]    sel    = div_sel[d*`PWMCG_SEL_W +: `PWMCG_SEL_W];
      wire [`PWMCG_FACTOR_W-1:0] factor = div_factor[d*`PWMCG_FACTOR_W +: `PWMCG_FACTOR_W];
      wire                       tick_in = (sel <= `PWMCG_SEL_LAST_TAP) ? tap_tick_o[sel] : 1'b0;
      reg  [`PWMCG_FACTOR_W-1:0] cnt_q;
      reg                        out_q;

      always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cnt_q <= `PWMCG_RST_FACTOR;
          out_q <= 1'b0;
        end else if (factor == `PWMCG_RST_FACTOR) begin
          cnt_q <= `PWMCG_RST_FACTOR;
          out_q <= 1'b0;
        end else if (tick_in && periph_clock_on_i) begin
          if (cnt_q >= factor - 8'h01) begin
            cnt_q <= `PWMCG_RST_FACTOR;
            out_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 8'h01;
            out_q <= 1'b0;
          end
        end else begin
          out_q <= 1'b0;
        end
      end

      assign div_out[d] = out_q;
    end
  endgenerate

  assign divided_clock_a_o = div_out[0];
  assign divided_clock_b_o = div_out[1];

endmodule // pwmcg_clkgen

// ### core/pwmcg_consts.vh
`ifndef PWMCG_CONSTS_VH
`define PWMCG_CONSTS_VH

// ----------------------------------------------------------------------------
// Structure
// ----------------------------------------------------------------------------
`define PWMCG_CHANNELS      4
`define PWMCG_CNT_W         16
`define PWMCG_SEL_W         4
`define PWMCG_FACTOR_W      8
`define PWMCG_TAPS          11
`define PWMCG_PRE_W         10

// ----------------------------------------------------------------------------
// Channel clock select codes
// ----------------------------------------------------------------------------
`define PWMCG_SEL_LAST_TAP  4'hA
`define PWMCG_SEL_DIV_A     4'hB
`define PWMCG_SEL_DIV_B     4'hC

// ----------------------------------------------------------------------------
// Reset values and dead-time counter saturation limit
// ----------------------------------------------------------------------------
`define PWMCG_RST_CNT       16'h0000
`define PWMCG_RST_PRE       10'h000
`define PWMCG_RST_FACTOR    8'h00
`define PWMCG_DT_SAT        16'hFFFF

`endif

// ### core/pwmcg_top.v
// Overview of operation
// - Prescaler gives master clock divided by every power of two to 1024.
// - Two linear dividers divide by an integer up to 255.
// - Each divider takes its selected prescaler tap and divides by its factor.
// - Divider factor zero leaves its divided clock stopped; fields reset to zero.
// - At reset or when gated off, only the undivided tap is active.
// - Four channels, each with a 16-bit counter on its selected clock.
// - Each channel picks its clock from taps or dividers; select resets zero.
// - Comparator uses channel 0 counter when the channel is a sync member.
// - Left aligned: count up to period minus one, restart at zero, period ends.
// - Centre aligned: count up to period minus one then down to zero.
// - Centre-aligned period is twice the left-aligned period for same value.
// - Comparator output derived from counter and duty values.
// - Constant low for duty equal period with polarity 0, or duty 0 polarity 1.
// - Constant high once enabled for duty 0 polarity 0, or duty equal period 1.
// - Polarity sets start level, applied while disabled, ignored while enabled.
// - Alignment bit selects left or centre counting; left by default.
// - Period-end event; centre mode event placement set by event-select bit.
// - Dead-time makes complementary outputs with gaps; enable changed only disabled.
// - Dead-time counter delays high edge to high delay, low edge to low delay.
// - Dead-time values loaded via update strobe, applied at next period event, or at once while disabled.
// - Separate inversion bit for each dead-time output.
// - Override stage then asynchronous fault stage with highest priority drive pins.
// - Fault forces programmed values asynchronously on an enabled channel and resets the channel counter.
// - Under override counters keep running, only pin levels are replaced.
// - Gated peripheral clock freezes state; operation resumes from it.
`timescale 1ns/1ps
`include "pwmcg_consts.vh"

module pwmcg_top #(
  parameter CHANNELS = `PWMCG_CHANNELS,
  parameter CNT_W    = `PWMCG_CNT_W
) (
  // Clock and reset
  input  wire                          ref_clk_i,
  input  wire                          sys_rst_i,
  // Power management gate
  input  wire                          periph_clock_on_i,
  // Clock generator configuration
  input  wire [`PWMCG_SEL_W-1:0]       divider_a_tap_select_i,
  input  wire [`PWMCG_SEL_W-1:0]       divider_b_tap_select_i,
  input  wire [`PWMCG_FACTOR_W-1:0]    divider_a_factor_i,
  input  wire [`PWMCG_FACTOR_W-1:0]    divider_b_factor_i,
  // Channel control, one bit or field per channel
  input  wire [CHANNELS-1:0]           channel_enable_i,
  input  wire [CHANNELS*`PWMCG_SEL_W-1:0] channel_clock_select_i,
  input  wire [CHANNELS*CNT_W-1:0]     channel_period_value_i,
  input  wire [CHANNELS*CNT_W-1:0]     channel_duty_value_i,
  input  wire [CHANNELS-1:0]           start_level_polarity_i,
  input  wire [CHANNELS-1:0]           alignment_select_i,
  input  wire [CHANNELS-1:0]           center_event_select_i,
  input  wire [CHANNELS-1:0]           sync_membership_bit_i,
  // Dead-time configuration
  input  wire [CHANNELS-1:0]           deadtime_enable_i,
  input  wire [CHANNELS-1:0]           high_side_invert_i,
  input  wire [CHANNELS-1:0]           low_side_invert_i,
  input  wire [CHANNELS-1:0]           deadtime_update_strobe_i,
  input  wire [CHANNELS*CNT_W-1:0]     high_side_delay_i,
  input  wire [CHANNELS*CNT_W-1:0]     low_side_delay_i,
  // Output override
  input  wire [CHANNELS-1:0]           override_select_i,
  input  wire [CHANNELS-1:0]           override_value_high_i,
  input  wire [CHANNELS-1:0]           override_value_low_i,
  // Fault protection
  input  wire [CHANNELS-1:0]           fault_active_i,
  input  wire [CHANNELS-1:0]           fault_value_high_i,
  input  wire [CHANNELS-1:0]           fault_value_low_i,
  // Outputs
  output wire [CHANNELS-1:0]           final_high_pin_o,
  output wire [CHANNELS-1:0]           final_low_pin_o,
  output wire [CHANNELS-1:0]           comparator_output_o,
  output wire [CHANNELS-1:0]           period_event_o,
  output wire [CHANNELS*CNT_W-1:0]     channel_counter_o
);

  // --------------------------------------------------------------------------
  // Clock generator
  // --------------------------------------------------------------------------
  wire [`PWMCG_TAPS-1:0] tap_tick;
  wire                   divided_clock_a;
  wire                   divided_clock_b;

  pwmcg_clkgen u_clkgen (
    .ref_clk_i              (ref_clk_i),
    .sys_rst_i              (sys_rst_i),
    .periph_clock_on_i      (periph_clock_on_i),
    .divider_a_tap_select_i (divider_a_tap_select_i),
    .divider_b_tap_select_i (divider_b_tap_select_i),
    .divider_a_factor_i     (divider_a_factor_i),
    .divider_b_factor_i     (divider_b_factor_i),
    .tap_tick_o             (tap_tick),
    .divided_clock_a_o      (divided_clock_a),
    .divided_clock_b_o      (divided_clock_b)
  );

  // --------------------------------------------------------------------------
  // Channel clock decode
  // --------------------------------------------------------------------------
  function sel_tick;
    input [`PWMCG_SEL_W-1:0] sel;
    input [`PWMCG_TAPS-1:0]  taps;
    input                    tick_a;
    input                    tick_b;
    begin
      if (sel <= `PWMCG_SEL_LAST_TAP) begin
        sel_tick = taps[sel];
      end else if (sel == `PWMCG_SEL_DIV_A) begin
        sel_tick = tick_a;
      end else if (sel == `PWMCG_SEL_DIV_B) begin
        sel_tick = tick_b;
      end else begin
        sel_tick = 1'b0;
      end
    end
  endfunction

  // A side turns on once its delay has run out
  function dt_gate;
    input             level;
    input             on;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] dly;
    begin
      dt_gate = on ? (level & (cnt >= dly)) : level;
    end
  endfunction

  wire [CHANNELS*CNT_W-1:0] cnt_all;
  wire [CNT_W-1:0]          cnt_ch0 = cnt_all[CNT_W-1:0];

  // --------------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c = c + 1) begin : g_ch
      // Sync members borrow clock, period and alignment of channel 0
      wire                     is_sync = (c != 0) && sync_membership_bit_i[c];
      wire [`PWMCG_SEL_W-1:0]  sel     = is_sync ? channel_clock_select_i[`PWMCG_SEL_W-1:0]
                                                 : channel_clock_select_i[c*`PWMCG_SEL_W +: `PWMCG_SEL_W];
      wire [CNT_W-1:0]         prd     = is_sync ? channel_period_value_i[CNT_W-1:0]
                                                 : channel_period_value_i[c*CNT_W +: CNT_W];
      wire                     alg     = is_sync ? alignment_select_i[0] : alignment_select_i[c];
      wire [CNT_W-1:0]         dty     = channel_duty_value_i[c*CNT_W +: CNT_W];
      wire                     en      = channel_enable_i[c];
      wire                     tick    = periph_clock_on_i
                                         & sel_tick(sel, tap_tick, divided_clock_a, divided_clock_b);
      wire [CNT_W-1:0]         prd_m1  = (prd == `PWMCG_RST_CNT) ? `PWMCG_RST_CNT : prd - 16'h0001;

      reg  [CNT_W-1:0]         cnt_q;
      reg                      dir_q;
      reg                      evt_q;
      reg                      pol_q;
      reg                      dtm_q;
      reg                      oc_q;
      reg                      flt_s1_q;
      reg                      flt_s2_q;
      reg                      flt_s3_q;
      reg                      flt_q;

      // Fault pin synchroniser; stages two and three must agree
      always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          flt_s1_q <= 1'b0;
          flt_s2_q <= 1'b0;
          flt_s3_q <= 1'b0;
          flt_q    <= 1'b0;
        end else begin
          flt_s1_q <= fault_active_i[c];
          flt_s2_q <= flt_s1_q;
          flt_s3_q <= flt_s2_q;
          if (flt_s2_q == flt_s3_q) begin
            flt_q <= flt_s3_q;
          end
        end
      end

      // Counter and period events
      always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cnt_q <= `PWMCG_RST_CNT;
          dir_q <= 1'b0;
          evt_q <= 1'b0;
        end else begin
          evt_q <= 1'b0;
          if (!en || flt_q) begin
            cnt_q <= `PWMCG_RST_CNT;
            dir_q <= 1'b0;
          end else if (tick) begin
            if (!alg) begin
              if (cnt_q >= prd_m1) begin
                cnt_q <= `PWMCG_RST_CNT;
                evt_q <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 16'h0001;
              end
            end else if (!dir_q) begin
              if (cnt_q >= prd_m1) begin
                dir_q <= 1'b1;
                evt_q <= center_event_select_i[c];
              end else begin
                cnt_q <= cnt_q + 16'h0001;
              end
            end else begin
              if (cnt_q == `PWMCG_RST_CNT) begin
                dir_q <= 1'b0;
                evt_q <= 1'b1;
              end else begin
                cnt_q <= cnt_q - 16'h0001;
              end
            end
          end
        end
      end

      // Comparator; polarity and dead-time enable only follow software while disabled
      wire [CNT_W-1:0] cmp_cnt = is_sync ? cnt_ch0 : cnt_q;

      always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          pol_q <= 1'b0;
          dtm_q <= 1'b0;
          oc_q  <= 1'b0;
        end else if (!en) begin
          pol_q <= start_level_polarity_i[c];
          dtm_q <= deadtime_enable_i[c];
          oc_q  <= start_level_polarity_i[c];
        end else begin
          oc_q  <= pol_q ^ (cmp_cnt >= dty);
        end
      end

      // Dead-time values: shadow loaded by strobe, applied at period event or while disabled
      reg  [CNT_W-1:0] hsd_q;
      reg  [CNT_W-1:0] lsd_q;
      reg  [CNT_W-1:0] hsd_sh_q;
      reg  [CNT_W-1:0] lsd_sh_q;
      reg              pend_q;

      always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          hsd_q    <= `PWMCG_RST_CNT;
          lsd_q    <= `PWMCG_RST_CNT;
          hsd_sh_q <= `PWMCG_RST_CNT;
          lsd_sh_q <= `PWMCG_RST_CNT;
          pend_q   <= 1'b0;
        end else if (deadtime_update_strobe_i[c]) begin
          // A new write beats a boundary landing in the same cycle
          hsd_sh_q <= high_side_delay_i[c*CNT_W +: CNT_W];
          lsd_sh_q <= low_side_delay_i[c*CNT_W +: CNT_W];
          pend_q   <= 1'b1;
        end else if (pend_q && (evt_q || !en)) begin
          hsd_q  <= hsd_sh_q;
          lsd_q  <= lsd_sh_q;
          pend_q <= 1'b0;
        end
      end

      // Dead-time generator
      reg  [CNT_W-1:0] dt_cnt_q;
      reg              oc_seen_q;
      reg              dt_high_q;
      reg              dt_low_q;
      wire             raw_high = dt_gate(oc_seen_q, dtm_q, dt_cnt_q, hsd_q);
      wire             raw_low  = dt_gate(~oc_seen_q, dtm_q, dt_cnt_q, lsd_q);

      always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          dt_cnt_q  <= `PWMCG_RST_CNT;
          oc_seen_q <= 1'b0;
          dt_high_q <= 1'b0;
          dt_low_q  <= 1'b0;
        end else begin
          if (oc_q != oc_seen_q) begin
            oc_seen_q <= oc_q;
            dt_cnt_q  <= `PWMCG_RST_CNT;
          end else if (tick && dt_cnt_q != `PWMCG_DT_SAT) begin
            dt_cnt_q  <= dt_cnt_q + 16'h0001;
          end
          dt_high_q <= raw_high ^ high_side_invert_i[c];
          dt_low_q  <= raw_low ^ low_side_invert_i[c];
        end
      end

      // Override, then fault; fault acts on the raw pin so it needs no clock edge
      wire ovr_high = override_select_i[c] ? override_value_high_i[c] : dt_high_q;
      wire ovr_low  = override_select_i[c] ? override_value_low_i[c] : dt_low_q;
      wire flt_now  = en & fault_active_i[c];

      assign final_high_pin_o[c]          = flt_now ? fault_value_high_i[c] : ovr_high;
      assign final_low_pin_o[c]           = flt_now ? fault_value_low_i[c] : ovr_low;
      assign comparator_output_o[c]       = oc_q;
      assign period_event_o[c]            = evt_q;
      assign cnt_all[c*CNT_W +: CNT_W]    = cnt_q;
    end
  endgenerate

  assign channel_counter_o = cnt_all;

endmodule // pwmcg_top

// ### dv/pwm_clockgen_channel_deadtime_tb.sv
`timescale 1ns/1ps
module pwm_clockgen_channel_deadtime_tb;
  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  reg         clk, rst, pon;
  reg  [3:0]  pa, pb, en, pol, alg, cev, syn, dtm, hi, li, stb, os, ovh, ovl, flt, fvh, fvl, mon;
  reg  [7:0]  fa, fb;
  reg  [15:0] sel, v;
  reg  [63:0] per, dty, dh, dl;
  wire [3:0]  ph, pl, oc, ev;
  wire [63:0] cnt;
  wire [15:0] shoot;
  integer     num_errors, check_count, cycles, k, j, g1, g2;

  pwmcg_top dut (.ref_clk_i(clk), .sys_rst_i(rst), .periph_clock_on_i(pon),
    .divider_a_tap_select_i(pa), .divider_b_tap_select_i(pb), .divider_a_factor_i(fa),
    .divider_b_factor_i(fb), .channel_enable_i(en), .channel_clock_select_i(sel),
    .channel_period_value_i(per), .channel_duty_value_i(dty), .start_level_polarity_i(pol),
    .alignment_select_i(alg), .center_event_select_i(cev), .sync_membership_bit_i(syn),
    .deadtime_enable_i(dtm), .high_side_invert_i(hi), .low_side_invert_i(li),
    .deadtime_update_strobe_i(stb), .high_side_delay_i(dh), .low_side_delay_i(dl),
    .override_select_i(os), .override_value_high_i(ovh), .override_value_low_i(ovl),
    .fault_active_i(flt), .fault_value_high_i(fvh), .fault_value_low_i(fvl),
    .final_high_pin_o(ph), .final_low_pin_o(pl), .comparator_output_o(oc),
    .period_event_o(ev), .channel_counter_o(cnt));
  pwmcg_switch_model u_switch (.ref_clk_i(clk), .sys_rst_i(rst), .gate_high_i(ph),
    .gate_low_i(pl), .watch_i(mon), .shoot_count_o(shoot));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  // Disable first so the setup starts a fresh period
  task cfg(input integer c, input logic [3:0] s, input logic [15:0] p, input logic [15:0] d, input logic a);
    begin
      en[c] = 1'b0;
      @(negedge clk);
      sel[c*4 +: 4] = s;
      per[c*16 +: 16] = p;
      dty[c*16 +: 16] = d;
      alg[c] = a;
      @(negedge clk);
      en[c] = 1'b1;
    end
  endtask
  task per_chk(input integer c, input integer e);
    integer n;
    begin
      n = 0;
      while (ev[c] !== 1'b1 && n < 9000) begin
        @(negedge clk);
        n = n + 1;
      end
      @(negedge clk);
      n = 1;
      while (ev[c] !== 1'b1 && n < 9000) begin
        @(negedge clk);
        n = n + 1;
      end
      chk("event spacing", e, n);
    end
  endtask
  task gap(output integer n);
    begin
      n = 0;
      while (pl[2] !== 1'b1) @(negedge clk);
      while (pl[2] !== 1'b0) @(negedge clk);
      while (ph[2] !== 1'b1 && n < 200) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task update_dt(input logic [15:0] h);
    begin
      dh[47:32] = h;
      dl[47:32] = 16'h0002;
      stb[2] = 1'b1;
      @(negedge clk);
      stb[2] = 1'b0;
    end
  endtask

  // ----------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  initial begin
    {num_errors, check_count, cycles} = 96'h0;
    {en, pol, alg, cev, syn, dtm, stb, os, ovh, ovl, flt, fvh, fvl, mon, pa, pb} = 64'h0;
    {fa, fb, sel, per, dty, dh, dl} = 288'h0;
    hi = 4'h8;
    li = 4'h8;
    pon = 1'b1;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("counters idle", 0, {31'h0, |cnt});
    chk("events and comparators", 0, {ev, oc});
    chk("inverted idle pins", 4'h9, {ph[3], pl[3], ph[2], pl[2]});
    cfg(1, 4'hB, 2, 1, 1'b0);
    repeat (40) @(negedge clk);
    chk("divider off counter", 0, cnt[31:16]);
    $display("test reset_state done");
    for (k = 0; k < 11; k = k + 1) if (k < 4 || k == 10) begin
      cfg(0, k[3:0], 5, 2, 1'b0);
      per_chk(0, 5 << k);
    end
    pa = 4'h1;
    fa = 8'h03;
    cfg(1, 4'hB, 4, 1, 1'b0);
    per_chk(1, 24);
    fb = 8'hFF;
    cfg(1, 4'hC, 2, 1, 1'b0);
    per_chk(1, 510);
    en[1] = 1'b0;
    cfg(0, 4'h0, 5, 2, 1'b1);
    per_chk(0, 10);
    cev[0] = 1'b1;
    cfg(0, 4'h0, 5, 2, 1'b1);
    per_chk(0, 5);
    $display("test clocks_and_periods done");
    for (k = 0; k < 4; k = k + 1) begin
      en[0] = 1'b0;
      pol[0] = k[0];
      cfg(0, 4'h0, 4, k[1] ? 16'h0004 : 16'h0000, 1'b0);
      repeat (4) @(negedge clk);
      for (j = 0; j < 12; j = j + 1) begin
        @(negedge clk);
        chk("fixed level", {k[0] ^ ~k[1]}, oc[0]);
      end
    end
    cfg(1, 4'h0, 4, 4, 1'b0);
    repeat (3) @(negedge clk);
    pol[1] = 1'b1;
    repeat (10) @(negedge clk);
    chk("polarity held", 0, oc[1]);
    en[1] = 1'b0;
    repeat (2) @(negedge clk);
    chk("polarity while idle", 1, oc[1]);
    pol[1] = 1'b0;
    $display("test levels_and_polarity done");
    en[0] = 1'b0;
    pol[0] = 1'b0;
    syn[1] = 1'b1;
    dty[31:16] = 16'h0003;
    per[31:16] = 16'h0002;
    cfg(0, 4'h0, 6, 2, 1'b0);
    en[1] = 1'b1;
    repeat (3) @(negedge clk);
    for (j = 0; j < 24; j = j + 1) begin
      v = cnt[15:0];
      @(negedge clk);
      chk("sync compare", {31'h0, v >= 16'h0003}, oc[1]);
    end
    {en[1], syn[1]} = 2'b00;
    cfg(0, 4'h0, 16'hF000, 1, 1'b0);
    repeat (20) @(negedge clk);
    pon = 1'b0;
    v = cnt[15:0];
    repeat (20) @(negedge clk);
    chk("frozen counter", v, cnt[15:0]);
    pon = 1'b1;
    repeat (5) @(negedge clk);
    chk("resumed counter", v + 16'h0005, cnt[15:0]);
    $display("test sync_and_freeze done");
    dtm[2] = 1'b1;
    update_dt(16'h0002);
    cfg(2, 4'h0, 40, 20, 1'b0);
    mon[2] = 1'b1;
    gap(g1);
    update_dt(16'h0006);
    gap(g2);
    chk("dead-time step", 4, g2 - g1);
    {os[2], ovh[2], ovl[2]} = 3'b110;
    @(negedge clk);
    chk("override pins", 2'b10, {ph[2], pl[2]});
    v = cnt[47:32];
    repeat (3) @(negedge clk);
    chk("override counter runs", 1, {31'h0, cnt[47:32] != v});
    {flt[2], fvh[2], fvl[2]} = 3'b101;
    #1;
    chk("fault pins", 2'b01, {ph[2], pl[2]});
    repeat (8) @(negedge clk);
    chk("fault counter", 0, cnt[47:32]);
    {flt[2], os[2]} = 2'b00;
    repeat (100) @(negedge clk);
    chk("shoot-through cycles", 0, shoot);
    $display("test deadtime_override_fault done");
    report_and_stop;
  end
endmodule // pwm_clockgen_channel_deadtime_tb

// ### dv/pwmcg_checker.sv
`timescale 1ns/1ps
module pwmcg_checker #(
  parameter CHANNELS = 4,
  parameter CNT_W    = 16
) (
  // Clock and reset
  input wire                      ref_clk_i,
  input wire                      sys_rst_i,
  // Channel control
  input wire [CHANNELS-1:0]       channel_enable_i,
  input wire [CHANNELS*CNT_W-1:0] channel_period_value_i,
  input wire [CHANNELS*CNT_W-1:0] channel_duty_value_i,
  input wire [CHANNELS-1:0]       start_level_polarity_i,
  input wire [CHANNELS-1:0]       alignment_select_i,
  input wire [CHANNELS-1:0]       deadtime_enable_i,
  input wire [CHANNELS-1:0]       high_side_invert_i,
  input wire [CHANNELS-1:0]       low_side_invert_i,
  // Override and fault
  input wire [CHANNELS-1:0]       override_select_i,
  input wire [CHANNELS-1:0]       override_value_high_i,
  input wire [CHANNELS-1:0]       override_value_low_i,
  input wire [CHANNELS-1:0]       fault_active_i,
  input wire [CHANNELS-1:0]       fault_value_high_i,
  input wire [CHANNELS-1:0]       fault_value_low_i,
  // Outputs
  input wire [CHANNELS-1:0]       final_high_pin_o,
  input wire [CHANNELS-1:0]       final_low_pin_o,
  input wire [CHANNELS-1:0]       comparator_output_o,
  input wire [CHANNELS-1:0]       period_event_o,
  input wire [CHANNELS*CNT_W-1:0] channel_counter_o
);
  // ----------------------------------------------------------------------------
  // Channel 0 carries the timing checks, channel 2 the fault-clear and dead-time checks; pin checks cover all channels
  // ----------------------------------------------------------------------------
  wire [CNT_W-1:0]    cnt0 = channel_counter_o[CNT_W-1:0];
  wire [CNT_W-1:0]    per0 = channel_period_value_i[CNT_W-1:0];
  wire [CNT_W-1:0]    duty0 = channel_duty_value_i[CNT_W-1:0];
  wire [CHANNELS-1:0] forced = fault_active_i & channel_enable_i;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence wrap_s;
    cnt0 == 0 && $past(cnt0) == $past(per0) - 1;
  endsequence
  // Three sync stages, agree step and counter clear
  sequence fault_held_s;
    fault_active_i[2] [*6];
  endsequence

  idle_count_zero_a: assert property (!channel_enable_i[0] |=> cnt0 == 0)
    else $error("counter not held at zero while disabled");
  compare_follows_a: assert property (channel_enable_i[0] && $past(channel_enable_i[0])
    && $stable(start_level_polarity_i[0]) |-> comparator_output_o[0] ==
    ($past(start_level_polarity_i[0]) ^ ($past(cnt0) >= $past(duty0))))
    else $error("comparator output does not follow counter and duty");
  event_at_wrap_a: assert property (period_event_o[0] && !alignment_select_i[0]
    && $past(channel_enable_i[0]) |-> wrap_s)
    else $error("period event without counter wrap");
  wrap_gives_event_a: assert property ((channel_enable_i[0] && $past(channel_enable_i[0])
    && !alignment_select_i[0] && $past(cnt0) != 0) ##0 wrap_s |-> period_event_o[0])
    else $error("counter wrap without period event");
  event_one_cycle_a: assert property (period_event_o[0] && per0 > 1 |=> !period_event_o[0])
    else $error("period event longer than one cycle");
  fault_pins_a: assert property (|forced |-> (((final_high_pin_o ^ fault_value_high_i)
    | (final_low_pin_o ^ fault_value_low_i)) & forced) == 0)
    else $error("pins not at fault values");
  override_pins_a: assert property (|(override_select_i & ~forced) |->
    (((final_high_pin_o ^ override_value_high_i) | (final_low_pin_o ^ override_value_low_i))
    & override_select_i & ~forced) == 0)
    else $error("pins not at override values");
  fault_clears_count_a: assert property (fault_held_s |-> channel_counter_o[2*CNT_W +: CNT_W] == 0)
    else $error("fault did not clear counter");
  gates_apart_a: assert property (channel_enable_i[2] && deadtime_enable_i[2] && !high_side_invert_i[2]
    && !low_side_invert_i[2] && !override_select_i[2] && !fault_active_i[2]
    |-> !(final_high_pin_o[2] && final_low_pin_o[2]))
    else $error("both dead-time outputs high");
endmodule // pwmcg_checker

bind pwmcg_top pwmcg_checker #(.CHANNELS(CHANNELS), .CNT_W(CNT_W)) u_checker (.*);

// ### dv/pwmcg_switch_model.sv
`timescale 1ns/1ps
module pwmcg_switch_model (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        sys_rst_i,
  // Gate drive and legs under watch
  input  wire [3:0]  gate_high_i,
  input  wire [3:0]  gate_low_i,
  input  wire [3:0]  watch_i,
  // Shoot-through tally
  output reg  [15:0] shoot_count_o
);
  // Both gates on shorts the leg, so tally each such cycle on a watched leg
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shoot_count_o <= 16'h0000;
    end else if (|(gate_high_i & gate_low_i & watch_i)) begin
      shoot_count_o <= shoot_count_o + 16'h0001;
    end
  end
endmodule // pwmcg_switch_model
